// ==== rtl/cpu_bus_regs.svh ====
// Purpose: constants for the processor bus cycle control block
// Assumes: state codes are written {s0, s1, s2}, left to right
// Notes:   definitions only, no logic
`ifndef CPU_BUS_REGS_SVH
`define CPU_BUS_REGS_SVH

// processor state codes, {s0, s1, s2}
`define ST_T1       3'h2
`define ST_T1I      3'h3
`define ST_T2       3'h1
`define ST_T3       3'h4
`define ST_T4       3'h7

// opcodes jammed onto the data bus
`define OPC_NOP     8'hC0
`define OPC_RST0    8'h05

// port selects on address bits 11..9
`define SEL_TTY_RX  3'h0
`define SEL_TTY_TX  3'h2
`define SEL_READER  3'h3

// field positions inside the latched high address
`define A13_BIT     5
`define A12_BIT     4
`define SEL_MSB     3
`define SEL_LSB     1

`endif

// ==== rtl/cpu_bus_pkg.sv ====
// Purpose: shared types of the processor bus cycle control block
// Assumes: one system clock, all processor pins sampled
// Notes:   reset value of the control group lives here as a typed constant
package cpu_bus_pkg;

   // status pins coming from the processor
   typedef struct packed {
      logic       phi1;
      logic       phi2;
      logic       sync;
      logic [2:0] state_code;
   } cpu_status_t;

   // cycle kind, {cycle_code_high, cycle_code_low}
   typedef enum logic [1:0] {
      CYC_FETCH = 2'h0,
      CYC_READ  = 2'h1,
      CYC_IO    = 2'h2,
      CYC_WRITE = 2'h3
   } cycle_kind_t;

   // strobes and enables to the system bus, all registered
   typedef struct packed {
      logic low_address_strobe_n;
      logic high_address_strobe_n;
      logic latched_address_to_bus_enable_n;
      logic processor_drive_direction;
      logic memory_read_enable;
      logic restart_board_bus_grant_n;
      logic port_read_select_n;
      logic port_write_strobe_n;
      logic flag_sample_strobe;
      logic memory_write_n;
      logic io_cycle;
      logic memory_write_cycle;
      logic memory_read_cycle;
      logic early_transfer_window;
   } bus_ctl_t;

   // latched address and cycle code
   typedef struct packed {
      logic       cycle_code_high;
      logic       cycle_code_low;
      logic [5:0] high;
      logic [7:0] low;
   } latched_addr_t;

   // idle levels: active-low strobes high, flag sample strobe low, processor owns the bus
   localparam bus_ctl_t CTL_IDLE = '{
      low_address_strobe_n            : 1'b1,
      high_address_strobe_n           : 1'b1,
      latched_address_to_bus_enable_n : 1'b1,
      processor_drive_direction       : 1'b1,
      memory_read_enable              : 1'b0,
      restart_board_bus_grant_n       : 1'b1,
      port_read_select_n              : 1'b1,
      port_write_strobe_n             : 1'b1,
      flag_sample_strobe              : 1'b0,
      memory_write_n                  : 1'b1,
      io_cycle                        : 1'b0,
      memory_write_cycle              : 1'b0,
      memory_read_cycle               : 1'b0,
      early_transfer_window           : 1'b0
   };

endpackage

// ==== rtl/cpu_bus_cycle_control.sv ====
// Purpose: decode processor states into system bus strobes, latch the
//          address, handle interrupt latching and opcode jamming
// Assumes: processor pins are asynchronous to clock and far slower
// Notes:   every output is one clock behind its decode
//
// What this block does
// - low strobe in first address state, sync-low phase two
// - low strobe samples acknowledge state, held
// - high strobe in second state latches upper address
// - early window flop set high strobe, gated sync
// - decode cycle code to io and write
// - write low from sync-high phase two till end
// - io with A12 or A13 means output
// - output op returns latched low byte in window
// - port write strobe during window sync phase two
// - direction high except window of non-write
// - port read select from window, io, input
// - flag sample in fourth state of input
// - memory read enable in window without acknowledge
// - teletype rise or button press sets request
// - acknowledge with second state clears request
// - teletype interrupt jams no-operation opcode
// - button flop selects restart-zero opcode instead
// - teletype interrupt follows falling start bit
// - port read select zero returns line level
// - output with A12 set, selects two, three latch bit zero
// - ready held high unless stall requested
// - acknowledge state decoded in place of first
// - request to processor changes on phase one
module cpu_bus_cycle_control
(
   input  wire logic                       clock,
   input  wire logic                       rstn,
   input  wire cpu_bus_pkg::cpu_status_t   cpu_status,
   input  wire logic [7:0]                 cpu_data_in,
   output logic      [7:0]                 cpu_data_out,
   output logic                            cpu_data_oe,
   input  wire logic [7:0]                 sys_data_in,
   output logic      [7:0]                 sys_data_out,
   output logic                            sys_data_oe,
   output cpu_bus_pkg::bus_ctl_t           bus_ctl,
   output cpu_bus_pkg::latched_addr_t      latched_addr,
   output logic                            cpu_interrupt,
   output logic                            processor_ready,
   input  wire logic                       stall_request,
   input  wire logic                       teletype_line,
   input  wire logic                       teletype_interrupt_gate,
   input  wire logic                       reset_button_sense,
   input  wire logic                       reset_button_ground_sense,
   output logic                            teletype_start_interrupt,
   output logic                            teletype_tx,
   output logic                            tape_reader_run
);
`include "cpu_bus_regs.svh"
   localparam int RAW_W = $bits(cpu_bus_pkg::cpu_status_t) + 21;
   // two-stage synchroniser for every pin
   logic [RAW_W-1:0]           meta_q;        // first stage, read only by sync_q
   logic [RAW_W-1:0]           sync_q;        // second stage, safe to decode
   cpu_bus_pkg::cpu_status_t   st_s;          // synchronised status pins
   logic [7:0]                 cpu_data_s;
   logic [7:0]                 sys_data_s;
   logic                       stall_s;
   logic                       line_s;
   logic                       gate_s;
   logic                       sense_s;
   logic                       ground_s;
   // registered state
   cpu_bus_pkg::bus_ctl_t      ctl_q,    ctl_d;
   cpu_bus_pkg::latched_addr_t addr_q,   addr_d;
   logic                       window_q, window_d;   // early window flop
   logic                       ack_q,    ack_d;      // acknowledge sampled
   logic                       irq_q,    irq_d;      // latched request
   logic                       cpu_int_q, cpu_int_d;
   logic                       button_q, button_d;   // opcode select
   logic                       press_q,  press_d;    // button level last clock
   logic                       teletype_start_interrupt_q, teletype_start_interrupt_d;
   logic                       tx_q,     tx_d;
   logic                       reader_q, reader_d;
   logic                       ready_q,  ready_d;
   logic                       phi1_q,   phi2_q;     // phase levels last clock
   logic [7:0]                 cpu_out_q, cpu_out_d;
   logic                       cpu_oe_q, cpu_oe_d;
   logic [7:0]                 sys_out_q, sys_out_d;
   logic                       sys_oe_q, sys_oe_d;
   // decode terms, kept visible for the checks below
   logic                       t1_any;
   logic                       t2;
   logic                       t3;
   logic                       t4;
   logic                       sync_low_phi2;
   logic                       lo_strobe;
   logic                       hi_strobe;
   logic                       window;
   logic                       io;
   logic                       wr;
   logic                       out_op;
   logic [2:0]                 port_sel;
   logic                       grant;
   logic                       rx_drive;
   logic                       press_rise;
   logic                       tty_rise;
   logic                       irq_set;
   logic                       irq_clear;
   logic                       phi1_rise;
   logic                       phi2_fall;
   cpu_bus_pkg::cycle_kind_t   kind;
   assign {st_s, cpu_data_s, sys_data_s, stall_s, line_s, gate_s, sense_s, ground_s} = sync_q;
   // pins cross into the clock domain through two flops
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= {cpu_status, cpu_data_in, sys_data_in, stall_request, teletype_line,
                    teletype_interrupt_gate, reset_button_sense, reset_button_ground_sense};
         sync_q <= meta_q;
      end
   end
   // next values of every control register
   always_comb
   begin
      t1_any        = st_s.state_code == `ST_T1 || st_s.state_code == `ST_T1I;
      t2            = st_s.state_code == `ST_T2;
      t3            = st_s.state_code == `ST_T3;
      t4            = st_s.state_code == `ST_T4;
      sync_low_phi2 = !st_s.sync && st_s.phi2;
      phi1_rise     = st_s.phi1 && !phi1_q;
      phi2_fall     = !st_s.phi2 && phi2_q;
      lo_strobe     = t1_any && sync_low_phi2;
      hi_strobe     = t2 && sync_low_phi2;
      kind          = cpu_bus_pkg::cycle_kind_t'({addr_q.cycle_code_high, addr_q.cycle_code_low});
      io            = kind == cpu_bus_pkg::CYC_IO;
      wr            = kind == cpu_bus_pkg::CYC_WRITE;
      out_op        = io && (addr_q.high[`A13_BIT] || addr_q.high[`A12_BIT]);
      port_sel      = addr_q.high[`SEL_MSB:`SEL_LSB];
      window        = window_q && st_s.sync;
      grant         = ack_q && window && !wr;
      rx_drive      = window && !wr && io && !out_op && port_sel == `SEL_TTY_RX;
      // address latches stay transparent while their strobe is low
      addr_d = addr_q;
      if (lo_strobe)
         addr_d.low = cpu_data_s;
      if (hi_strobe)
      begin
         addr_d.high            = cpu_data_s[5:0];
         addr_d.cycle_code_low  = cpu_data_s[6];
         addr_d.cycle_code_high = cpu_data_s[7];
      end
      // acknowledge flag taken at the start of each low strobe
      ack_d = ack_q;
      if (lo_strobe && ctl_q.low_address_strobe_n)
         ack_d = st_s.state_code == `ST_T1I;
      // early window: set by high strobe, ended by sync low in transfer
      window_d = window_q;
      if (hi_strobe)
         window_d = 1'b1;
      else if (t3 && !st_s.sync)
         window_d = 1'b0;
      ctl_d                                 = ctl_q;
      ctl_d.low_address_strobe_n            = !lo_strobe;
      ctl_d.high_address_strobe_n           = !hi_strobe;
      ctl_d.early_transfer_window           = window;
      ctl_d.io_cycle                        = io;
      ctl_d.memory_write_cycle              = wr;
      ctl_d.memory_read_cycle               = kind == cpu_bus_pkg::CYC_READ;
      ctl_d.latched_address_to_bus_enable_n = !(out_op && window);
      ctl_d.port_write_strobe_n             = !(out_op && window && st_s.phi2);
      ctl_d.processor_drive_direction       = !(window && !wr);
      ctl_d.port_read_select_n              = !(window && !wr && io && !out_op);
      ctl_d.flag_sample_strobe              = io && !out_op && t4 && sync_low_phi2;
      ctl_d.restart_board_bus_grant_n       = !grant;
      ctl_d.memory_read_enable              = window && !wr && !io && !ack_q;
      // write goes low in sync-high phase two, back at end of sync-low phase two
      if (!wr)
         ctl_d.memory_write_n = 1'b1;
      else if (t3 && st_s.sync && st_s.phi2)
         ctl_d.memory_write_n = 1'b0;
      else if (phi2_fall && !st_s.sync)
         ctl_d.memory_write_n = 1'b1;
      // interrupt sources; a set in the clearing clock wins
      teletype_start_interrupt_d  = gate_s && !line_s;
      tty_rise   = teletype_start_interrupt_d && !teletype_start_interrupt_q;
      press_d    = sense_s && !ground_s;
      press_rise = press_d && !press_q;
      irq_set    = tty_rise || press_rise;
      irq_clear  = ack_q && t2 && sync_low_phi2;
      irq_d      = irq_set || (irq_q && !irq_clear);
      button_d   = press_rise || (button_q && !tty_rise);
      // processor sees the request change only on a phase one edge
      cpu_int_d = phi1_rise ? irq_q : cpu_int_q;
      ready_d   = !stall_s;

      // output port latches, taken as the write strobe opens
      tx_d     = tx_q;
      reader_d = reader_q;
      if (!ctl_d.port_write_strobe_n && ctl_q.port_write_strobe_n && addr_q.high[`A12_BIT])
      begin
         if (port_sel == `SEL_TTY_TX)
            tx_d = addr_q.low[0];
         if (port_sel == `SEL_READER)
            reader_d = addr_q.low[0];
      end

      // system bus source, jammed opcode first
      sys_oe_d  = 1'b1;
      if (grant)
         sys_out_d = button_q ? `OPC_RST0 : `OPC_NOP;
      else if (out_op && window)
         sys_out_d = addr_q.low;
      else if (rx_drive)
         sys_out_d = {7'h00, line_s};
      else
      begin
         sys_out_d = cpu_data_s;
         sys_oe_d  = ctl_d.processor_drive_direction;
      end

      // processor side of the bus switch sees the resolved system bus
      cpu_oe_d  = !ctl_d.processor_drive_direction;
      cpu_out_d = sys_oe_d ? sys_out_d : sys_data_s;
   end

   // registers of the control group
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         ctl_q     <= cpu_bus_pkg::CTL_IDLE;
         addr_q    <= '0;
         window_q  <= 1'b0;
         ack_q     <= 1'b0;
         irq_q     <= 1'b0;
         cpu_int_q <= 1'b0;
         button_q  <= 1'b0;
         press_q   <= 1'b0;
         teletype_start_interrupt_q <= 1'b0;
         tx_q      <= 1'b1;
         reader_q  <= 1'b0;
         ready_q   <= 1'b1;
         phi1_q    <= 1'b0;
         phi2_q    <= 1'b0;
         cpu_out_q <= 8'h00;
         cpu_oe_q  <= 1'b0;
         sys_out_q <= 8'h00;
         sys_oe_q  <= 1'b0;
      end
      else
      begin
         ctl_q     <= ctl_d;
         addr_q    <= addr_d;
         window_q  <= window_d;
         ack_q     <= ack_d;
         irq_q     <= irq_d;
         cpu_int_q <= cpu_int_d;
         button_q  <= button_d;
         press_q   <= press_d;
         teletype_start_interrupt_q <= teletype_start_interrupt_d;
         tx_q      <= tx_d;
         reader_q  <= reader_d;
         ready_q   <= ready_d;
         phi1_q    <= st_s.phi1;
         phi2_q    <= st_s.phi2;
         cpu_out_q <= cpu_out_d;
         cpu_oe_q  <= cpu_oe_d;
         sys_out_q <= sys_out_d;
         sys_oe_q  <= sys_oe_d;
      end
   end

   assign bus_ctl                  = ctl_q;
   assign latched_addr             = addr_q;
   assign cpu_interrupt            = cpu_int_q;
   assign processor_ready          = ready_q;
   assign teletype_start_interrupt = teletype_start_interrupt_q;
   assign teletype_tx              = tx_q;
   assign tape_reader_run          = reader_q;
   assign cpu_data_out             = cpu_out_q;
   assign cpu_data_oe              = cpu_oe_q;
   assign sys_data_out             = sys_out_q;
   assign sys_data_oe              = sys_oe_q;

   // checks on the driven outputs
   a_low_latch:
   assert property (@(posedge clock) disable iff (!rstn)
      $rose(ctl_q.low_address_strobe_n) |-> addr_q.low == $past(cpu_data_s, 2))
      else $error("low address not captured at strobe end");
   a_dir_window:
   assert property (@(posedge clock) disable iff (!rstn)
      !ctl_q.processor_drive_direction |-> $past(window_q && !wr))
      else $error("direction low outside window of non-write");
   a_read_excl:
   assert property (@(posedge clock) disable iff (!rstn)
      ctl_q.memory_read_enable |-> ctl_q.restart_board_bus_grant_n
         && ctl_q.port_read_select_n && !ctl_q.io_cycle)
      else $error("memory read enable overlaps another bus owner");
   a_grant_ack:
   assert property (@(posedge clock) disable iff (!rstn)
      !ctl_q.restart_board_bus_grant_n |-> $past(ack_q) && !ctl_q.memory_write_cycle)
      else $error("grant without acknowledged interrupt");
   a_port_excl:
   assert property (@(posedge clock) disable iff (!rstn)
      !(!ctl_q.port_read_select_n && !ctl_q.latched_address_to_bus_enable_n))
      else $error("input and output selected together");
   a_write_cycle:
   assert property (@(posedge clock) disable iff (!rstn)
      $fell(ctl_q.memory_write_n) |-> $past(st_s.sync && t3 && wr))
      else $error("write asserted outside write cycle transfer");
   a_flag_input:
   assert property (@(posedge clock) disable iff (!rstn)
      ctl_q.flag_sample_strobe |-> $past(io && !out_op && t4 && !st_s.sync))
      else $error("flag sample outside input fourth state");
   a_irq_set:
   assert property (@(posedge clock) disable iff (!rstn)
      irq_set |=> irq_q)
      else $error("interrupt source lost");
   a_irq_clear:
   assert property (@(posedge clock) disable iff (!rstn)
      irq_clear && !irq_set |=> !irq_q)
      else $error("request not cleared after acknowledge");
   a_int_phase:
   assert property (@(posedge clock) disable iff (!rstn)
      $changed(cpu_int_q) |-> $past(st_s.phi1 && !phi1_q))
      else $error("processor request changed off phase one edge");
   a_jam_opcode:
   assert property (@(posedge clock) disable iff (!rstn)
      $past(grant && !button_q) |-> sys_oe_q && sys_out_q == `OPC_NOP)
      else $error("wrong opcode for teletype interrupt");
   a_jam_restart:
   assert property (@(posedge clock) disable iff (!rstn)
      $past(grant && button_q) |-> sys_oe_q && sys_out_q == `OPC_RST0)
      else $error("wrong opcode for button interrupt");

endmodule

// ==== tb/cpu_model.sv ====
// Purpose: behavioural processor for the bus cycle control bench
// Assumes: phases run free; released data pins float high on pull-ups
// Notes:   idle states use an unused code, so no strobe should fire there
`include "cpu_bus_regs.svh"
module cpu_model
#(
   parameter int PH = 3 // clocks per phase pulse, far shorter than real parts
)
(
   input  wire logic                     clock,
   input  wire logic                     start,
   input  wire logic [1:0]               kind,
   input  wire logic [13:0]              addr,
   input  wire logic [7:0]               data,
   input  wire logic                     ack,
   input  wire logic                     ready,
   output cpu_bus_pkg::cpu_status_t      status,
   output logic [7:0]                    pins,
   output logic                          busy
);
   timeunit 1ns;
   timeprecision 1ps;
   // one state: sync-high half then sync-low half, each phi1, gap, phi2, gap
   task automatic run_state(input logic [2:0] code, input logic [7:0] d);
      int k;
      int m;
      for (k = 0; k < 8 * PH; k++)
      begin
         m = k % (4 * PH);
         @(posedge clock);
         status.state_code <= code;
         status.sync       <= k < 4 * PH;
         status.phi1       <= m < PH;
         status.phi2       <= m >= 2 * PH && m < 3 * PH;
         pins              <= d;
      end
   endtask
   // requests taken at a state boundary only, so a cycle never starts mid-state
   initial
   begin
      status = '0;
      pins   = 8'hFF;
      busy   = 1'b0;
      forever
      begin
         if (start && !busy)
         begin
            busy <= 1'b1;
            run_state(ack ? `ST_T1I : `ST_T1, addr[7:0]);
            run_state(`ST_T2, {kind, addr[13:8]});
            // wait states while ready is held low
            while (ready !== 1'b1)
               run_state(3'h0, 8'hFF);
            run_state(`ST_T3, kind == cpu_bus_pkg::CYC_WRITE ? data : 8'hFF);
            run_state(`ST_T4, kind == cpu_bus_pkg::CYC_IO ? data : 8'hFF);
            busy <= 1'b0;
         end
         else
            run_state(3'h6, 8'hFF);
      end
   end
endmodule

// ==== tb/cpu_bus_cycle_control_tb_top.sv ====
// Purpose: self-checking bench for cpu_bus_cycle_control
// Assumes: cpu_model makes the phases; the system bus floats high when idle
// Notes:   strobe activity is gathered over one cycle and judged after it
`include "cpu_bus_regs.svh"
module cpu_bus_cycle_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] FETCH = cpu_bus_pkg::CYC_FETCH, READ = cpu_bus_pkg::CYC_READ;
   localparam logic [1:0] IO = cpu_bus_pkg::CYC_IO, WRITE = cpu_bus_pkg::CYC_WRITE;
   logic clock = 1'b0, rstn = 1'b0, start = 1'b0, ack = 1'b0, seen_clr = 1'b1;
   logic stall_request = 1'b0, teletype_line = 1'b1, teletype_interrupt_gate = 1'b1;
   logic reset_button_sense = 1'b0, reset_button_ground_sense = 1'b1;
   logic busy, cpu_data_oe, sys_data_oe, cpu_interrupt, processor_ready;
   logic teletype_start_interrupt, teletype_tx, tape_reader_run;
   logic [1:0]                 kind = 2'h0;   // cycle code sent in T2
   logic [13:0]                addr = '0;     // address sent in T1 and T2
   logic [7:0]                 wdata = '0, pins, cpu_data_out, sys_data_out;
   logic [9:0]                 seen, now_v;   // strobe activity, active-high view
   logic [8:0]                 cap;           // {oe, byte} put on the system bus
   logic [8:0]                 cpu_cap;       // {oe, byte} handed to the processor
   int                         n_checks = 0, n_mismatch = 0;
   cpu_bus_pkg::cpu_status_t   cpu_status;
   cpu_bus_pkg::bus_ctl_t      bus_ctl;
   cpu_bus_pkg::latched_addr_t latched_addr;
   // 250 MHz system clock
   initial
      forever
         #2 clock = ~clock;
   // processor pins resolve between the block and the model
   cpu_bus_cycle_control u_dut
   (
      .clock(clock), .rstn(rstn), .cpu_status(cpu_status),
      .cpu_data_in(cpu_data_oe ? cpu_data_out : pins), .cpu_data_out(cpu_data_out),
      .cpu_data_oe(cpu_data_oe), .sys_data_in(sys_data_oe ? sys_data_out : 8'hFF),
      .sys_data_out(sys_data_out), .sys_data_oe(sys_data_oe), .bus_ctl(bus_ctl),
      .latched_addr(latched_addr), .cpu_interrupt(cpu_interrupt),
      .processor_ready(processor_ready), .stall_request(stall_request),
      .teletype_line(teletype_line), .teletype_interrupt_gate(teletype_interrupt_gate),
      .reset_button_sense(reset_button_sense),
      .reset_button_ground_sense(reset_button_ground_sense),
      .teletype_start_interrupt(teletype_start_interrupt), .teletype_tx(teletype_tx),
      .tape_reader_run(tape_reader_run)
   );
   cpu_model u_cpu
   (
      .clock(clock), .start(start), .kind(kind), .addr(addr), .data(wdata), .ack(ack),
      .ready(processor_ready), .status(cpu_status), .pins(pins), .busy(busy)
   );
   // bit order: grant, flag, read sel, write strobe, return, write, dir low, mre, hi, lo
   assign now_v = {~bus_ctl.restart_board_bus_grant_n, bus_ctl.flag_sample_strobe,
                   ~bus_ctl.port_read_select_n, ~bus_ctl.port_write_strobe_n,
                   ~bus_ctl.latched_address_to_bus_enable_n, ~bus_ctl.memory_write_n,
                   ~bus_ctl.processor_drive_direction, bus_ctl.memory_read_enable,
                   ~bus_ctl.high_address_strobe_n, ~bus_ctl.low_address_strobe_n};
   // sticky activity; last byte driven while the block owns the system bus
   always @(posedge clock)
   begin
      seen <= seen_clr ? '0 : (seen | now_v);
      if (now_v[9] || now_v[7] || now_v[5])
         cap <= {sys_data_oe, sys_data_out};
      // last byte fed back to the processor while the system bus drives it
      if (now_v[3])
         cpu_cap <= {cpu_data_oe, cpu_data_out};
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   // closing report, the one place the run ends
   task automatic end_of_test();
      $display("TB: %0d checks, %0d mismatches", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t %s: got %h, expected %h", $time, what, got, exp);
      end
   endtask
   // a bounded wait ran out: count it and stop
   task automatic timeout(input string what);
      n_mismatch++;
      $display("ERROR t=%0t %s: no response in time", $time, what);
      end_of_test();
   endtask
   // one processor cycle; request held until the model has taken it
   task automatic cyc(input logic [1:0] k, input logic [13:0] a, input logic [7:0] d,
                      input logic i, input logic [9:0] ev);
      int         n;
      logic [1:0] ed;
      ed = {k == IO, k == WRITE};
      @(posedge clock);
      kind     <= k;
      addr     <= a;
      wdata    <= d;
      ack      <= i;
      start    <= 1'b1;
      seen_clr <= 1'b1;
      for (n = 0; n < 60 && busy !== 1'b1; n++)
         @(posedge clock);
      if (busy !== 1'b1)
         timeout("cycle start");
      start    <= 1'b0;
      seen_clr <= 1'b0;
      for (n = 0; n < 600 && busy !== 1'b0; n++)
         @(posedge clock);
      if (busy !== 1'b0)
         timeout("cycle end");
      tick(8);
      chk(16'(seen), 16'(ev), "strobes");
      chk(16'(latched_addr), {k, a}, "latched address");
      chk(16'({bus_ctl.io_cycle, bus_ctl.memory_write_cycle}), 16'(ed), "decode");
   endtask
   task automatic wait_int(input logic v);
      int n;
      for (n = 0; n < 300 && cpu_interrupt !== v; n++)
         @(posedge clock);
      if (cpu_interrupt !== v)
         timeout("interrupt request");
   endtask
   // idle levels while reset is held
   task automatic t_reset();
      logic [4:0] pv;
      #1;
      pv = {teletype_tx, processor_ready, cpu_interrupt, cpu_data_oe, sys_data_oe};
      chk(16'(bus_ctl), 16'(cpu_bus_pkg::CTL_IDLE), "idle controls");
      chk(16'(pv), 16'h0018, "idle pins");
   endtask
   // memory cycles back to back
   task automatic t_mem();
      cyc(FETCH, 14'h0123, 8'h00, 1'b0, 10'h00F);
      cyc(READ, 14'h3FFF, 8'h00, 1'b0, 10'h00F);
      chk(16'(cpu_cap), 16'h01FF, "memory data to processor");
      cyc(WRITE, 14'h2AA5, 8'h3C, 1'b0, 10'h013);
      chk(16'(bus_ctl.memory_write_n), 16'h0001, "write released");
   endtask
   // output with each top bit, teletype transmit, reader, teletype receive
   task automatic t_io();
      cyc(IO, 14'h205A, 8'hA5, 1'b0, 10'h06B);
      chk(16'(cap), 16'h015A, "returned accumulator");
      cyc(IO, 14'h1400, 8'hFF, 1'b0, 10'h06B);
      chk(16'(teletype_tx), 16'h0000, "transmit bit");
      cyc(IO, 14'h1601, 8'h00, 1'b0, 10'h06B);
      chk(16'(tape_reader_run), 16'h0001, "reader run");
      cyc(IO, 14'h0033, 8'h0F, 1'b0, 10'h18B);
      chk(16'(cap), 16'h0101, "received line");
   endtask
   // button then start bit, each acknowledged with a jammed opcode
   task automatic t_int();
      @(posedge clock);
      reset_button_sense        <= 1'b1;
      reset_button_ground_sense <= 1'b0;
      wait_int(1'b1);
      reset_button_sense        <= 1'b0;
      reset_button_ground_sense <= 1'b1;
      cyc(FETCH, 14'h0040, 8'h00, 1'b1, 10'h20B);
      chk(16'(cap), {7'h00, 1'b1, `OPC_RST0}, "restart opcode");
      chk(16'(cpu_cap), {7'h00, 1'b1, `OPC_RST0}, "restart to processor");
      chk(16'(cpu_interrupt), 16'h0000, "request cleared");
      teletype_line <= 1'b0;
      tick(6);
      chk(16'(teletype_start_interrupt), 16'h0001, "start bit");
      wait_int(1'b1);
      cyc(FETCH, 14'h0041, 8'h00, 1'b1, 10'h20B);
      chk(16'(cap), {7'h00, 1'b1, `OPC_NOP}, "no-operation opcode");
      chk(16'(cpu_cap), {7'h00, 1'b1, `OPC_NOP}, "no-op to processor");
      teletype_line           <= 1'b1;
      teletype_interrupt_gate <= 1'b0;
      tick(2);
      teletype_line <= 1'b0;
      tick(60);
      chk(16'({teletype_start_interrupt, cpu_interrupt}), 16'h0000, "gated off");
      teletype_line <= 1'b1;
      tick(2);
      teletype_interrupt_gate <= 1'b1;
   endtask
   // ready held low stretches the cycle until released
   task automatic t_stall();
      @(posedge clock);
      stall_request <= 1'b1;
      tick(6);
      chk(16'(processor_ready), 16'h0000, "ready low");
      fork
         cyc(READ, 14'h0200, 8'h00, 1'b0, 10'h00F);
         begin
            tick(150);
            chk(16'(busy), 16'h0001, "stalled");
            stall_request <= 1'b0;
         end
      join
      chk(16'(processor_ready), 16'h0001, "ready high");
   endtask
   // reset for two cycles, then the scenarios in turn
   initial
   begin
      tick(1);
      t_reset();
      @(posedge clock);
      rstn <= 1'b1;
      tick(4);
      t_mem();
      t_io();
      t_int();
      t_stall();
      end_of_test();
   end
endmodule
